// file: design/group_check_pkg.sv
package group_check_pkg;

  // Register byte offsets on the APB window.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0C;

  // Field positions and reset values.
  localparam int CTRL_VLCHK_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int STAT_ILLEGAL_BIT = 0;
  localparam int STAT_VLRES_BIT = 1;
  localparam int STAT_CLAMP_BIT = 2;
  localparam int STAT_W = 3;
  localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 3'h0;
  localparam int COUNT_W = 16;

  // Fixed shape of the hashing group instructions and base group size, as log2 values.
  localparam logic [2:0] HASH_EGS_LOG2 = 3'h2;
  localparam logic [2:0] HASH_EEW_LOG2 = 3'h5;
  localparam logic [2:0] BASE_EGS_LOG2 = 3'h0;

  // Legal range of the effective register-group multiplier, log2.
  localparam int EFFECTIVE_REG_GROUP_MULTIPLIER_MIN_LOG2 = -3;
  localparam int EFFECTIVE_REG_GROUP_MULTIPLIER_MAX_LOG2 = 3;

  // Decode latency in clock cycles.
  localparam int DEC_LATENCY = 1;

  typedef enum logic [2:0] {
    OP_BASE = 3'b001,
    OP_GROUP = 3'b010,
    OP_HASH = 3'b100
  } op_kind_t;

  typedef struct packed {
    logic [2:0] egs_log2;
    logic eew_static;
    logic [2:0] eew_log2;
  } opnd_req_t;

  // Operand 0 is the destination, 1 and 2 the sources.
  typedef struct packed {
    logic valid;
    op_kind_t kind;
    logic whole_group;
    logic [2:0] vec_of_groups;
    opnd_req_t [2:0] opnd;
  } issue_req_t;

  typedef struct packed {
    logic [2:0] sew_log2;
    logic signed [3:0] reg_group_multiplier_log2;
  } vtype_t;

  typedef struct packed {
    logic [2:0] egs_log2;
    logic [2:0] eew_log2;
    logic signed [3:0] effective_reg_group_multiplier_log2;
    logic [3:0] gbw_log2;
  } opnd_res_t;

  typedef struct packed {
    logic valid;
    logic illegal;
    logic vl_reserved;
    logic commit_en;
    logic simultaneous;
    logic mask_en;
    opnd_res_t [2:0] opnd;
  } dec_res_t;

endpackage : group_check_pkg

// file: design/vector_element_group_checker.sv
// Function
// RULE_01: Group sizes are powers of two; sizes above the supported maximum trap.
// RULE_02: Each operand's group size comes from the opcode, not dynamic state.
// RULE_03: A group size above the maximum vector length raises illegal.
// RULE_04: Base vector instructions use group size one and never fail group checks.
// RULE_05: Active length must be a multiple of group size for group vectors.
// RULE_06: Over-long requests give the maximum length, a multiple of largest group.
// RULE_07: Software picks a suitable element width for group instructions.
// RULE_08: The dynamic element width sizes one element, not the whole group.
// RULE_09: An opcode may fix element widths, ignoring the dynamic width.
// RULE_10: The register-group multiplier drives each operand's effective multiplier.
// RULE_11: Every operand carries its own group size, multiplier and width.
// RULE_12: Four 8-bit elements reduced to one 32-bit element keep equal multipliers.
// RULE_13: Group bits are size times width; wide groups span joined registers.
// RULE_14: Hashing group instructions use group size 4 and element width 32.
// RULE_15: Some groups go to the unit whole, others element by element.
// RULE_16: Group instructions execute with no mask control.
// RULE_17: A failed group check traps before any register or length update.
`timescale 1ns/100ps
module vector_element_group_checker #(
  parameter int VECTOR_REGISTER_BITS = 128,
  parameter int VL_W = 16,
  parameter int LARGEST_GROUP_ELEM_LOG2 = 2
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input group_check_pkg::issue_req_t ISSUE_I,
  input group_check_pkg::vtype_t VTYPE_I,
  input wire logic [VL_W-1:0] VL_I,
  input wire logic AVL_VALID_I,
  input wire logic [VL_W-1:0] AVL_I,
  output group_check_pkg::dec_res_t DEC_O,
  output logic VL_VALID_O,
  output logic [VL_W-1:0] VL_O,
  output logic IRQ_O
);

  localparam int VECTOR_REGISTER_BITS_LOG2 = $clog2(VECTOR_REGISTER_BITS);

  if ((VECTOR_REGISTER_BITS & (VECTOR_REGISTER_BITS - 1)) != 0 ||
      VECTOR_REGISTER_BITS < 8 || VECTOR_REGISTER_BITS_LOG2 >= VL_W ||
      LARGEST_GROUP_ELEM_LOG2 > 7) begin : g_bad_param
    $error("Unsupported vector_element_group_checker parameters.");
  end

  int max_vector_length_log2;
  logic is_group;
  logic [2:0] egs_w [3];
  logic [2:0] eew_w [3];
  int effective_reg_group_multiplier_w [3];
  int gbw_w [3];
  logic [2:0] bad_w;
  logic [2:0] vl_bad_w;
  group_check_pkg::dec_res_t dec_next;
  group_check_pkg::dec_res_t dec_reg;
  logic [VL_W-1:0] max_vector_length_val;
  logic [VL_W-1:0] vl_next;
  logic [VL_W-1:0] vl_reg;
  logic vl_valid_reg;
  logic clamp_next;
  logic [31:0] ctrl_reg;
  logic [group_check_pkg::STAT_W-1:0] status_reg;
  logic [group_check_pkg::STAT_W-1:0] status_next;
  logic [group_check_pkg::STAT_W-1:0] mask_reg;
  logic [group_check_pkg::STAT_W-1:0] events;
  logic [group_check_pkg::COUNT_W-1:0] count_reg;
  logic [31:0] prdata_reg;
  logic clamp_reg;
  logic wr_en;
  logic mapped;

  // The maximum vector length in elements, as log2, from the vtype.
  always_comb begin
    max_vector_length_log2 = VECTOR_REGISTER_BITS_LOG2 + int'(VTYPE_I.reg_group_multiplier_log2)
      - int'(VTYPE_I.sew_log2);
    is_group = ISSUE_I.kind != group_check_pkg::OP_BASE;
  end

  for (genvar i = 0; i < 3; i++) begin : g_opnd
    // Group size comes only from the opcode class and operand fields, never from the vtype. RULE_02
    always_comb begin
      unique case (ISSUE_I.kind)
        group_check_pkg::OP_HASH: begin
          egs_w[i] = group_check_pkg::HASH_EGS_LOG2; // RULE_14
          eew_w[i] = group_check_pkg::HASH_EEW_LOG2; // RULE_09
        end
        group_check_pkg::OP_GROUP: begin
          egs_w[i] = ISSUE_I.opnd[i].egs_log2; // RULE_11
          eew_w[i] = ISSUE_I.opnd[i].eew_static ?
            ISSUE_I.opnd[i].eew_log2 : VTYPE_I.sew_log2; // RULE_08
        end
        default: begin
          egs_w[i] = group_check_pkg::BASE_EGS_LOG2; // RULE_04
          eew_w[i] = ISSUE_I.opnd[i].eew_static ?
            ISSUE_I.opnd[i].eew_log2 : VTYPE_I.sew_log2;
        end
      endcase
    end

    // Multiplier scales with group bits relative to the destination, so a
    // four-by-8-bit source reduced to one 32-bit result keeps the same
    // multiplier as that result. RULE_10 RULE_12
    always_comb begin
      effective_reg_group_multiplier_w[i] = int'(VTYPE_I.reg_group_multiplier_log2) + int'(eew_w[i])
        + int'(egs_w[i]) - int'(VTYPE_I.sew_log2) - int'(egs_w[0]);
      gbw_w[i] = int'(egs_w[i]) + int'(eew_w[i]); // RULE_13
    end

    // Power-of-two size is implied by the log2 code; the size limit,
    // the length limit, the multiplier range and register joining remain.
    assign bad_w[i] =
      (int'(egs_w[i]) > LARGEST_GROUP_ELEM_LOG2) || // RULE_01
      (int'(egs_w[i]) > max_vector_length_log2) || // RULE_03
      (effective_reg_group_multiplier_w[i] < group_check_pkg::EFFECTIVE_REG_GROUP_MULTIPLIER_MIN_LOG2) ||
      (effective_reg_group_multiplier_w[i] > group_check_pkg::EFFECTIVE_REG_GROUP_MULTIPLIER_MAX_LOG2) ||
      (gbw_w[i] > VECTOR_REGISTER_BITS_LOG2 &&
       effective_reg_group_multiplier_w[i] < gbw_w[i] - VECTOR_REGISTER_BITS_LOG2); // RULE_13

    // Lengths that split a group are reserved and trapped when enabled.
    assign vl_bad_w[i] = ISSUE_I.vec_of_groups[i] &&
      ctrl_reg[group_check_pkg::CTRL_VLCHK_BIT] &&
      ((VL_I & VL_W'((32'h1 << egs_w[i]) - 32'h1)) != '0); // RULE_05
  end

  always_comb begin
    dec_next = '0;
    dec_next.valid = ISSUE_I.valid;
    // Base instructions are never rejected by group checks. RULE_04
    dec_next.vl_reserved = ISSUE_I.valid && is_group && (|vl_bad_w);
    dec_next.illegal = ISSUE_I.valid && is_group &&
      ((|bad_w) || (|vl_bad_w)); // RULE_03
    // No write-back or length update is allowed on a trap. RULE_17
    dec_next.commit_en = ISSUE_I.valid && !dec_next.illegal;
    dec_next.simultaneous = ISSUE_I.valid && is_group &&
      ISSUE_I.whole_group; // RULE_15
    dec_next.mask_en = ISSUE_I.valid && !is_group; // RULE_16
    for (int k = 0; k < 3; k++) begin
      dec_next.opnd[k].egs_log2 = egs_w[k];
      dec_next.opnd[k].eew_log2 = eew_w[k];
      dec_next.opnd[k].effective_reg_group_multiplier_log2 = 4'(effective_reg_group_multiplier_w[k]);
      dec_next.opnd[k].gbw_log2 = 4'(gbw_w[k]);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      dec_reg <= '0;
    end else begin
      dec_reg <= dec_next;
    end
  end

  // Maximum length is a power of two, so it is also a whole multiple of
  // the largest group size whenever it can hold one group. RULE_06
  always_comb begin
    if (max_vector_length_log2 < 0) begin
      max_vector_length_val = '0;
    end else begin
      max_vector_length_val = VL_W'(1) << max_vector_length_log2;
    end
    clamp_next = AVL_VALID_I && (AVL_I > max_vector_length_val);
    vl_next = (AVL_I > max_vector_length_val) ? max_vector_length_val : AVL_I; // RULE_06
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      vl_reg <= '0;
      vl_valid_reg <= 1'b0;
      clamp_reg <= 1'b0;
    end else begin
      vl_valid_reg <= AVL_VALID_I;
      clamp_reg <= clamp_next;
      if (AVL_VALID_I) begin
        vl_reg <= vl_next;
      end
    end
  end

  // APB slave: zero wait states, error on unmapped offsets.
  always_comb begin
    mapped = (PADDR_I == group_check_pkg::OFF_CTRL) ||
      (PADDR_I == group_check_pkg::OFF_STATUS) ||
      (PADDR_I == group_check_pkg::OFF_MASK) ||
      (PADDR_I == group_check_pkg::OFF_COUNT);
    wr_en = PSEL_I && PENABLE_I && PWRITE_I && mapped;
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      ctrl_reg <= group_check_pkg::CTRL_RST;
      mask_reg <= group_check_pkg::MASK_RST;
    end else if (wr_en) begin
      if (PADDR_I == group_check_pkg::OFF_CTRL) begin
        ctrl_reg <= {31'h0, PWDATA_I[group_check_pkg::CTRL_VLCHK_BIT]};
      end
      if (PADDR_I == group_check_pkg::OFF_MASK) begin
        mask_reg <= PWDATA_I[group_check_pkg::STAT_W-1:0];
      end
    end
  end

  // Sticky events; a new event wins over a same-cycle write-one clear.
  always_comb begin
    events = '0;
    events[group_check_pkg::STAT_ILLEGAL_BIT] = dec_reg.illegal;
    events[group_check_pkg::STAT_VLRES_BIT] = dec_reg.vl_reserved;
    events[group_check_pkg::STAT_CLAMP_BIT] = clamp_reg;
    status_next = status_reg;
    if (wr_en && PADDR_I == group_check_pkg::OFF_STATUS) begin
      status_next = status_reg & ~PWDATA_I[group_check_pkg::STAT_W-1:0];
    end
    status_next = status_next | events;
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      status_reg <= group_check_pkg::STAT_RST;
      count_reg <= '0;
    end else begin
      status_reg <= status_next;
      if (dec_reg.illegal) begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  // Read data is captured in the setup cycle and held through access.
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      prdata_reg <= '0;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      unique case (PADDR_I)
        group_check_pkg::OFF_CTRL: prdata_reg <= ctrl_reg;
        group_check_pkg::OFF_STATUS: prdata_reg <= {29'h0, status_reg};
        group_check_pkg::OFF_MASK: prdata_reg <= {29'h0, mask_reg};
        group_check_pkg::OFF_COUNT: prdata_reg <= {16'h0, count_reg};
        default: prdata_reg <= '0;
      endcase
    end
  end

  assign PRDATA_O = prdata_reg;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
  assign DEC_O = dec_reg;
  assign VL_O = vl_reg;
  assign VL_VALID_O = vl_valid_reg;
  assign IRQ_O = |(status_reg & mask_reg);

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!NRST_I);

  a_base_never_trap: assert property ( // RULE_04
    ISSUE_I.valid && ISSUE_I.kind == group_check_pkg::OP_BASE
    |=> DEC_O.valid && !DEC_O.illegal && DEC_O.commit_en)
    else $error("Base instruction rejected by group check.");

  a_trap_no_commit: assert property ( // RULE_17
    DEC_O.valid && DEC_O.illegal |-> !DEC_O.commit_en)
    else $error("Trapped instruction still commits.");

  a_hash_shape: assert property ( // RULE_14
    ISSUE_I.valid && ISSUE_I.kind == group_check_pkg::OP_HASH
    |=> DEC_O.opnd[1].egs_log2 == 3'h2 && DEC_O.opnd[1].eew_log2 == 3'h5
      && DEC_O.opnd[0].gbw_log2 == 4'h7)
    else $error("Hash group shape not size 4 width 32.");

  a_static_width: assert property ( // RULE_09
    ISSUE_I.valid && ISSUE_I.kind == group_check_pkg::OP_GROUP &&
    ISSUE_I.opnd[2].eew_static
    |=> DEC_O.opnd[2].eew_log2 == $past(ISSUE_I.opnd[2].eew_log2))
    else $error("Static element width not honoured.");

  a_dynamic_width: assert property ( // RULE_08
    ISSUE_I.valid && ISSUE_I.kind == group_check_pkg::OP_GROUP &&
    !ISSUE_I.opnd[1].eew_static
    |=> DEC_O.opnd[1].eew_log2 == $past(VTYPE_I.sew_log2))
    else $error("Dynamic element width not taken from vtype.");

  a_size_over_max: assert property ( // RULE_03
    ISSUE_I.valid && ISSUE_I.kind == group_check_pkg::OP_GROUP &&
    int'(ISSUE_I.opnd[0].egs_log2) > max_vector_length_log2
    |=> DEC_O.illegal ##1 status_reg[group_check_pkg::STAT_ILLEGAL_BIT])
    else $error("Group larger than vector length not trapped.");

  a_size_unsupported: assert property ( // RULE_01
    ISSUE_I.valid && ISSUE_I.kind == group_check_pkg::OP_GROUP &&
    int'(ISSUE_I.opnd[2].egs_log2) > LARGEST_GROUP_ELEM_LOG2
    |=> DEC_O.illegal && !DEC_O.commit_en)
    else $error("Unsupported group size not trapped.");

  a_vl_multiple: assert property ( // RULE_05
    ISSUE_I.valid && ISSUE_I.kind == group_check_pkg::OP_HASH &&
    ISSUE_I.vec_of_groups[0] && ctrl_reg[0] && VL_I[1:0] != 2'h0
    |=> DEC_O.vl_reserved && DEC_O.illegal)
    else $error("Length splitting a group not trapped.");

  a_vl_clamp: assert property ( // RULE_06
    AVL_VALID_I && AVL_I > max_vector_length_val
    |=> VL_VALID_O && VL_O == $past(max_vector_length_val) && VL_O != '0)
    else $error("Over-long request not clamped to maximum.");

  a_vl_pass: assert property ( // RULE_06
    AVL_VALID_I && AVL_I <= max_vector_length_val |=> VL_O == $past(AVL_I))
    else $error("Fitting request length altered.");

  a_equal_mult: assert property ( // RULE_12
    ISSUE_I.valid && ISSUE_I.kind == group_check_pkg::OP_GROUP &&
    ISSUE_I.opnd[0].egs_log2 == 3'h0 && (ISSUE_I.opnd[0].eew_static ?
      ISSUE_I.opnd[0].eew_log2 == 3'h5 : VTYPE_I.sew_log2 == 3'h5) &&
    ISSUE_I.opnd[1].egs_log2 == 3'h2 &&
    ISSUE_I.opnd[1].eew_static && ISSUE_I.opnd[1].eew_log2 == 3'h3
    |=> DEC_O.opnd[1].effective_reg_group_multiplier_log2 == DEC_O.opnd[0].effective_reg_group_multiplier_log2)
    else $error("Reduced group multipliers differ.");

  a_no_mask: assert property ( // RULE_16
    ISSUE_I.valid && ISSUE_I.kind != group_check_pkg::OP_BASE
    |=> !DEC_O.mask_en)
    else $error("Mask control applied to group instruction.");

  a_base_one_elem: assert property ( // RULE_04
    ISSUE_I.valid && ISSUE_I.kind == group_check_pkg::OP_BASE
    |=> DEC_O.opnd[0].egs_log2 == 3'h0 && DEC_O.opnd[2].egs_log2 == 3'h0
      && DEC_O.mask_en && !DEC_O.vl_reserved)
    else $error("Base instruction given a group size above one.");

  a_hash_fixed: assert property ( // RULE_02
    ISSUE_I.valid && ISSUE_I.kind == group_check_pkg::OP_HASH
    |=> DEC_O.opnd[0].egs_log2 == 3'h2 && DEC_O.opnd[2].egs_log2 == 3'h2
      && DEC_O.opnd[0].eew_log2 == 3'h5 && DEC_O.opnd[2].eew_log2 == 3'h5)
    else $error("Hash group shape taken from operand fields.");

  a_size_limit: assert property ( // RULE_01
    DEC_O.valid && !DEC_O.illegal
    |-> int'(DEC_O.opnd[1].egs_log2) <= LARGEST_GROUP_ELEM_LOG2
      && int'(DEC_O.opnd[2].egs_log2) <= LARGEST_GROUP_ELEM_LOG2)
    else $error("Unsupported group size let through.");

  a_opnd_own: assert property ( // RULE_11
    ISSUE_I.valid && ISSUE_I.kind == group_check_pkg::OP_GROUP
    |=> DEC_O.opnd[1].egs_log2 == $past(ISSUE_I.opnd[1].egs_log2)
      && DEC_O.opnd[2].egs_log2 == $past(ISSUE_I.opnd[2].egs_log2))
    else $error("Operand group size not kept per operand.");

  a_dest_mult: assert property ( // RULE_10
    ISSUE_I.valid && ISSUE_I.kind == group_check_pkg::OP_GROUP &&
    !ISSUE_I.opnd[0].eew_static
    |=> DEC_O.opnd[0].effective_reg_group_multiplier_log2 == $past(VTYPE_I.reg_group_multiplier_log2))
    else $error("Destination multiplier not taken from vtype.");

  a_join_regs: assert property ( // RULE_13
    DEC_O.valid && !DEC_O.mask_en && !DEC_O.illegal &&
    int'(DEC_O.opnd[2].gbw_log2) > VECTOR_REGISTER_BITS_LOG2
    |-> int'($signed(DEC_O.opnd[2].effective_reg_group_multiplier_log2)) >=
      int'(DEC_O.opnd[2].gbw_log2) - VECTOR_REGISTER_BITS_LOG2)
    else $error("Wide group not spread over joined registers.");

  a_whole_group: assert property ( // RULE_15
    ISSUE_I.valid && ISSUE_I.kind != group_check_pkg::OP_BASE
    |=> DEC_O.simultaneous == $past(ISSUE_I.whole_group))
    else $error("Whole-group delivery flag lost.");

  a_vl_check_off: assert property ( // RULE_05
    ISSUE_I.valid && !ctrl_reg[group_check_pkg::CTRL_VLCHK_BIT]
    |=> !DEC_O.vl_reserved)
    else $error("Length check applied while disabled.");

  a_status_set: assert property ( // RULE_05
    DEC_O.vl_reserved |=> status_reg[group_check_pkg::STAT_VLRES_BIT])
    else $error("Reserved length event lost.");

  a_clamp_flag: assert property ( // RULE_06
    clamp_reg |=> status_reg[group_check_pkg::STAT_CLAMP_BIT])
    else $error("Clamped length event lost.");

endmodule : vector_element_group_checker

// file: tb/issue_stage_model.sv
`timescale 1ns/100ps
module issue_stage_model (
  input wire logic clk_i,
  output group_check_pkg::issue_req_t issue_o,
  output group_check_pkg::vtype_t vtype_o,
  output logic [15:0] vl_o
);
  initial begin
    issue_o = '0;
    vtype_o = '0;
    vl_o = 16'h0000;
  end

  // One request stands for one cycle; afterwards its fields are scrambled.
  task automatic send(input group_check_pkg::issue_req_t r,
    input group_check_pkg::vtype_t t, input logic [15:0] l);
    group_check_pkg::issue_req_t n;
    n = ~r;
    n.valid = 1'b0;
    @(posedge clk_i);
    issue_o <= r;
    vtype_o <= t;
    vl_o <= l;
    @(posedge clk_i);
    issue_o <= n;
  endtask : send
endmodule : issue_stage_model

// file: tb/vector_element_group_checker_tb_top.sv
`timescale 1ns/100ps
module vector_element_group_checker_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic avl_valid = 1'b0;
  logic [15:0] requested_app_length = 16'h0000;
  logic vl_valid;
  logic [15:0] vl_out;
  logic [15:0] vl;
  logic irq;
  group_check_pkg::issue_req_t iss;
  group_check_pkg::vtype_t vt;
  group_check_pkg::dec_res_t dec;
  int errors = 0;
  int samples_checked = 0;
  int cnt_m = 0;
  logic [2:0] st_m = 3'h0;
  logic chk_m = 1'b1;

  always #2.5 clk = ~clk;

  issue_stage_model isp (.clk_i(clk), .issue_o(iss), .vtype_o(vt),
    .vl_o(vl));
  vector_element_group_checker dut (.CLK_I(clk), .NRST_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .ISSUE_I(iss), .VTYPE_I(vt),
    .VL_I(vl), .AVL_VALID_I(avl_valid), .AVL_I(requested_app_length), .DEC_O(dec),
    .VL_VALID_O(vl_valid), .VL_O(vl_out), .IRQ_O(irq));

  task automatic stop_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic check(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      check(1'b0, "apb timeout");
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic group_check_pkg::issue_req_t mk(
    group_check_pkg::op_kind_t k, logic [2:0] g, logic s, logic [2:0] w);
    group_check_pkg::issue_req_t r;
    r = '0;
    r.valid = 1'b1;
    r.kind = k;
    r.whole_group = 1'b1;
    r.vec_of_groups = 3'h7;
    for (int i = 0; i < 3; i++) r.opnd[i] = '{g, s, w};
    return r;
  endfunction : mk

  function automatic group_check_pkg::dec_res_t model(
    group_check_pkg::issue_req_t r, group_check_pkg::vtype_t t, int l);
    group_check_pkg::dec_res_t d;
    int selected_elem_width, lm, e, vmax, g, g0, w, em, gw;
    bit grp, hash, bad, res;
    d = '0;
    selected_elem_width = t.sew_log2;
    lm = t.reg_group_multiplier_log2;
    e = 7 + lm - selected_elem_width;
    vmax = (e < 0) ? 0 : (1 << e);
    grp = r.kind != group_check_pkg::OP_BASE;
    hash = r.kind == group_check_pkg::OP_HASH;
    bad = 0;
    res = 0;
    g0 = !grp ? 0 : (hash ? 2 : r.opnd[0].egs_log2);
    for (int k = 0; k < 3; k++) begin
      g = !grp ? 0 : (hash ? 2 : r.opnd[k].egs_log2);
      w = hash ? 5 : (r.opnd[k].eew_static ? r.opnd[k].eew_log2 : selected_elem_width);
      em = lm + w + g - selected_elem_width - g0;
      gw = g + w;
      if (g > 2 || (1 << g) > vmax || em < -3 || em > 3) bad = 1;
      if (gw > 7 && em < gw - 7) bad = 1;
      if (r.vec_of_groups[k] && l % (1 << g) != 0) res = 1;
      d.opnd[k] = '{3'(g), 3'(w), 4'(em), 4'(gw)};
    end
    d.valid = 1'b1;
    d.vl_reserved = grp && chk_m && res;
    d.illegal = grp && (bad || d.vl_reserved);
    d.commit_en = !d.illegal;
    d.simultaneous = grp && r.whole_group;
    d.mask_en = !grp;
    return d;
  endfunction : model

  task automatic issue(input group_check_pkg::issue_req_t r,
    input group_check_pkg::vtype_t t, input logic [15:0] l);
    group_check_pkg::dec_res_t x;
    x = model(r, t, l);
    isp.send(r, t, l);
    #1;
    check(dec === x, "decode result");
    if (x.illegal) begin
      cnt_m++;
      st_m[0] = 1'b1;
    end
    if (x.vl_reserved) st_m[1] = 1'b1;
  endtask : issue

  task automatic len(input logic [15:0] a, input int vmax);
    @(posedge clk);
    avl_valid <= 1'b1;
    requested_app_length <= a;
    @(posedge clk);
    avl_valid <= 1'b0;
    requested_app_length <= ~a;
    #1;
    check(vl_valid === 1'b1 && vl_out === 16'(a > vmax ? vmax : a),
      "length");
    if (a > vmax) st_m[2] = 1'b1;
  endtask : len

  initial begin
    group_check_pkg::issue_req_t r;
    group_check_pkg::vtype_t t;
    logic [31:0] rd;
    logic er;
    void'($urandom(23));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b1, group_check_pkg::OFF_COUNT, 32'h0000_FFFF, rd, er);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0, rd, er);
      check(rd === (i == 0 ? group_check_pkg::CTRL_RST : 32'h0), "reset");
    end
    apb(1'b1, 8'h10, 32'hFFFF_FFFF, rd, er);
    apb(1'b0, 8'h10, 32'h0, rd, er);
    check(rd === 32'h0 && er === 1'b1, "unmapped");
    t.sew_log2 = 3'h5;
    t.reg_group_multiplier_log2 = 4'h0;
    r = mk(group_check_pkg::OP_HASH, 3'h0, 1'b0, 3'h3);
    issue(r, t, 16'h0004);
    issue(r, t, 16'h0006);
    apb(1'b1, group_check_pkg::OFF_CTRL, 32'h0, rd, er);
    chk_m = 1'b0;
    issue(r, t, 16'h0006);
    apb(1'b1, group_check_pkg::OFF_CTRL, 32'h1, rd, er);
    chk_m = 1'b1;
    issue(mk(group_check_pkg::OP_GROUP, 3'h3, 1'b0, 3'h0), t, 16'h8);
    t.sew_log2 = 3'h6;
    t.reg_group_multiplier_log2 = 4'hF;
    issue(mk(group_check_pkg::OP_GROUP, 3'h1, 1'b0, 3'h0), t, 16'h2);
    t.sew_log2 = 3'h3;
    t.reg_group_multiplier_log2 = 4'h0;
    r = mk(group_check_pkg::OP_GROUP, 3'h2, 1'b1, 3'h3);
    r.opnd[0] = '{3'h0, 1'b1, 3'h5};
    r.vec_of_groups = 3'h6;
    issue(r, t, 16'h0008);
    check(dec.opnd[0].effective_reg_group_multiplier_log2 === dec.opnd[1].effective_reg_group_multiplier_log2, "effective_reg_group_multiplier");
    issue(mk(group_check_pkg::OP_GROUP, 3'h2, 1'b1, 3'h6), t, 16'h8);
    t.sew_log2 = 3'h4;
    issue(mk(group_check_pkg::OP_BASE, 3'h3, 1'b0, 3'h0), t, 16'h3);
    apb(1'b0, group_check_pkg::OFF_STATUS, 32'h0, rd, er);
    check(rd === 32'(st_m) && irq === 1'b0, "masked irq");
    apb(1'b1, group_check_pkg::OFF_MASK, 32'h7, rd, er);
    apb(1'b0, group_check_pkg::OFF_MASK, 32'h0, rd, er);
    check(rd === 32'h7 && irq === 1'b1, "irq raised");
    apb(1'b1, group_check_pkg::OFF_STATUS, 32'h7, rd, er);
    st_m = 3'h0;
    apb(1'b0, group_check_pkg::OFF_STATUS, 32'h0, rd, er);
    check(rd === 32'h0 && irq === 1'b0, "irq cleared");
    for (int n = 0; n < 150; n++) begin
      r = mk(group_check_pkg::op_kind_t'(3'h1 << $urandom_range(2)),
        3'h0, 1'b0, 3'h3);
      for (int k = 0; k < 3; k++)
        r.opnd[k] = '{3'($urandom_range(2)), 1'($urandom),
          3'($urandom_range(6, 3))};
      if (r.kind == group_check_pkg::OP_BASE)
        for (int k = 0; k < 3; k++) r.opnd[k].eew_static = 1'b0;
      r.whole_group = 1'($urandom);
      r.vec_of_groups = 3'($urandom);
      t.sew_log2 = 3'($urandom_range(6, 3));
      t.reg_group_multiplier_log2 = 4'($urandom_range(6) - 3);
      issue(r, t, 16'($urandom_range(20)));
    end
    t.sew_log2 = 3'h5;
    t.reg_group_multiplier_log2 = 4'h1;
    issue(mk(group_check_pkg::OP_BASE, 3'h0, 1'b0, 3'h5), t, 16'h0);
    len(16'h0000, 8);
    len(16'h0008, 8);
    len(16'h0009, 8);
    len(16'hFFFF, 8);
    apb(1'b0, group_check_pkg::OFF_STATUS, 32'h0, rd, er);
    check(rd === 32'(st_m), "status");
    apb(1'b0, group_check_pkg::OFF_COUNT, 32'h0, rd, er);
    check(rd === 32'(16'(cnt_m)), "count");
    stop_test();
  end
endmodule : vector_element_group_checker_tb_top
